/* File: rtl/svot_cfg.svh */
`ifndef SVOT_CFG_SVH
`define SVOT_CFG_SVH
`define SVOT_CLK_NS      40
`define SVOT_SETTLE_NS   2000
`define SVOT_SETTLE_CYC  ((`SVOT_SETTLE_NS + `SVOT_CLK_NS - 1) / `SVOT_CLK_NS)
`define SVOT_FB_US       20000
`define SVOT_FB_CYC      ((`SVOT_FB_US * 1000) / `SVOT_CLK_NS)
`define SVOT_RB_OFF      2'h0
`define SVOT_RB_HS       2'h2
`define SVOT_RB_BOTH     2'h3
`define SVOT_LINK_CNT_W  5
`define SVOT_LINK_DATA   3'h4
`define SVOT_GAIN_SHIFT  8
`endif

/* File: rtl/svot_pkg.sv */
package svot_pkg;
  typedef enum logic [3:0] {
    SVOT_OFF    = 4'b0000,
    SVOT_OPEN1  = 4'b0001,
    SVOT_OPEN2  = 4'b0010,
    SVOT_OPEN3  = 4'b0011,
    SVOT_ON     = 4'b0100,
    SVOT_CLOSE3 = 4'b0101,
    SVOT_CLOSE2 = 4'b0110,
    SVOT_CLOSE1 = 4'b0111,
    SVOT_FAULT  = 4'b1000
  } svot_state_e;
endpackage : svot_pkg

/* File: rtl/svot_natfreq.sv */
`timescale 1ns/10ps
`default_nettype none
module svot_natfreq
  import svot_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        params_load,
  input  wire logic [31:0] axis_stiffness,
  input  wire logic [15:0] axis_mass,
  output logic             natfreq_busy,
  output logic [31:0]      natfreq_sq
);
  // Restoring division stiffness / mass, one quotient bit per cycle.
  logic        busy_r, busy_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [16:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [15:0] div_r, div_nxt;
  logic [31:0] res_r, res_nxt;
  logic [16:0] rem_sh;

  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt  = cnt_r;
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    div_nxt  = div_r;
    res_nxt  = res_r;
    rem_sh   = {rem_r[15:0], quo_r[31]};
    if (params_load && !busy_r) begin
      busy_nxt = 1'b1;
      cnt_nxt  = 6'h00;
      rem_nxt  = 17'h00000;
      quo_nxt  = axis_stiffness;
      div_nxt  = axis_mass;
    end else if (busy_r) begin
      quo_nxt = {quo_r[30:0], 1'b0};
      rem_nxt = rem_sh;
      if (rem_sh >= {1'b0, div_r}) begin
        rem_nxt    = rem_sh - {1'b0, div_r};
        quo_nxt[0] = 1'b1;
      end
      cnt_nxt = cnt_r + 6'h01;
      if (cnt_r == 6'h1F) begin
        busy_nxt = 1'b0;
        res_nxt  = quo_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 6'h00;
      rem_r  <= 17'h00000;
      quo_r  <= 32'h00000000;
      div_r  <= 16'h0000;
      res_r  <= 32'h00000000;
    end else if (clk_en) begin
      busy_r <= busy_nxt;
      cnt_r  <= cnt_nxt;
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      div_r  <= div_nxt;
      res_r  <= res_nxt;
    end
  end

  assign natfreq_busy = busy_r;
  assign natfreq_sq   = res_r;
endmodule : svot_natfreq
`default_nettype wire

/* File: rtl/svot_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "svot_cfg.svh"
module svot_top
  import svot_pkg::*;
#(
  parameter int FB_CYC = `SVOT_FB_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        safe_stop_request,
  input  wire logic        diag_hi_pin,
  input  wire logic        diag_lo_pin,
  input  wire logic        valve_fb_pin,
  input  wire logic        fault_clear,
  input  wire logic        ch1_valve_config,
  input  wire logic        ch2_valve_config,
  input  wire logic        params_load,
  input  wire logic [31:0] axis_stiffness,
  input  wire logic [15:0] axis_mass,
  input  wire logic [15:0] pos_setpoint,
  input  wire logic [15:0] pos_actual,
  output logic             hs_switch_on,
  output logic             ls_switch_on,
  output logic             valve_energized,
  output logic             ch1_valve_fault,
  output logic             ch2_valve_fault,
  output logic             test_busy,
  output logic             link_tx,
  output logic             natfreq_busy,
  output logic [31:0]      natfreq_sq,
  output logic [15:0]      ctrl_out
);
  localparam int FBW = $clog2(FB_CYC + 1);
  localparam logic [7:0] SETTLE = 8'(`SVOT_SETTLE_CYC);

  // Pin inputs: stop, diag hi, diag lo, valve feedback.
  logic [3:0] pin_in;
  logic [3:0] pin_s;
  assign pin_in = {valve_fb_pin, diag_lo_pin, diag_hi_pin, safe_stop_request};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (clk_en) begin
          meta_r <= pin_in[gi];
          sync_r <= meta_r;
        end
      end
      assign pin_s[gi] = sync_r;
    end
  endgenerate

  logic       stop_s;
  logic [1:0] rb_s;
  logic       fb_s;
  assign stop_s = pin_s[0];
  assign rb_s   = {pin_s[1], pin_s[2]};
  assign fb_s   = pin_s[3];

  // Commanded readback pattern for each sequencer state.
  function automatic logic [1:0] svot_cmd(input svot_state_e s);
    case (s)
      SVOT_OPEN2, SVOT_CLOSE2:           svot_cmd = `SVOT_RB_HS;
      SVOT_OPEN3, SVOT_ON, SVOT_CLOSE3:  svot_cmd = `SVOT_RB_BOTH;
      default:                           svot_cmd = `SVOT_RB_OFF;
    endcase
  endfunction : svot_cmd

  svot_state_e    st_r, st_nxt;
  logic [7:0]     settle_r, settle_nxt;
  logic [FBW-1:0] fb_cnt_r, fb_cnt_nxt;
  logic           hs_r, hs_nxt;
  logic           ls_r, ls_nxt;
  logic           f1_r, f1_nxt;
  logic           f2_r, f2_nxt;
  logic           chk_en;
  logic           stable;
  logic           fb_due;
  logic           f1_set;
  logic           f2_set;

  assign chk_en = (settle_r == 8'h00);
  assign stable = (st_r == SVOT_OFF) || (st_r == SVOT_ON);
  assign fb_due = stable && (fb_cnt_r == FBW'(FB_CYC));

  // Channel one trusts the state table; channel two trusts the switch flops.
  // Keeping the two references apart lets a corrupted state be caught.
  always_comb begin
    f1_set = 1'b0;
    f2_set = 1'b0;
    if (chk_en) begin
      if (rb_s != svot_cmd(st_r)) begin
        f1_set = 1'b1;
      end
      if (rb_s != {hs_r, ls_r}) begin
        f2_set = 1'b1;
      end
    end
    if (fb_due) begin
      if (ch1_valve_config && (fb_s != (st_r == SVOT_ON))) begin
        f1_set = 1'b1;
      end
      if (ch2_valve_config && (fb_s != (hs_r & ls_r))) begin
        f2_set = 1'b1;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    f1_nxt = f1_set | (f1_r & ~fault_clear);
    f2_nxt = f2_set | (f2_r & ~fault_clear);
    if ((st_r != SVOT_FAULT) && (f1_set || f2_set || f1_r || f2_r)) begin
      st_nxt = SVOT_FAULT;
    end else begin
      case (st_r)
        SVOT_OFF: begin
          if (!stop_s) begin
            st_nxt = SVOT_OPEN1;
          end
        end
        SVOT_OPEN1: begin
          if (chk_en) begin
            st_nxt = stop_s ? SVOT_OFF : SVOT_OPEN2;
          end
        end
        SVOT_OPEN2: begin
          if (chk_en) begin
            st_nxt = stop_s ? SVOT_CLOSE1 : SVOT_OPEN3;
          end
        end
        SVOT_OPEN3: begin
          if (chk_en) begin
            st_nxt = stop_s ? SVOT_CLOSE3 : SVOT_ON;
          end
        end
        SVOT_ON: begin
          if (stop_s) begin
            st_nxt = SVOT_CLOSE3;
          end
        end
        SVOT_CLOSE3: begin
          if (chk_en) begin
            st_nxt = SVOT_CLOSE2;
          end
        end
        SVOT_CLOSE2: begin
          if (chk_en) begin
            st_nxt = SVOT_CLOSE1;
          end
        end
        SVOT_CLOSE1: begin
          if (chk_en) begin
            st_nxt = SVOT_OFF;
          end
        end
        SVOT_FAULT: begin
          // A fresh stop select is demanded before the switches may move again.
          if (fault_clear && !f1_set && !f2_set && stop_s) begin
            st_nxt = SVOT_OFF;
          end
        end
        default: st_nxt = SVOT_FAULT;
      endcase
    end
    {hs_nxt, ls_nxt} = svot_cmd(st_nxt);
    settle_nxt = (st_nxt != st_r) ? SETTLE : (chk_en ? 8'h00 : settle_r - 8'h01);
    fb_cnt_nxt = fb_cnt_r;
    if (st_nxt != st_r) begin
      fb_cnt_nxt = '0;
    end else if (!fb_due) begin
      fb_cnt_nxt = fb_cnt_r + FBW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r     <= SVOT_OFF;
      settle_r <= 8'h00;
      fb_cnt_r <= '0;
      hs_r     <= 1'b0;
      ls_r     <= 1'b0;
      f1_r     <= 1'b0;
      f2_r     <= 1'b0;
    end else if (clk_en) begin
      st_r     <= st_nxt;
      settle_r <= settle_nxt;
      fb_cnt_r <= fb_cnt_nxt;
      hs_r     <= hs_nxt;
      ls_r     <= ls_nxt;
      f1_r     <= f1_nxt;
      f2_r     <= f2_nxt;
    end
  end

  // Serial link frame: start, diag hi, diag lo, odd parity, then four idle bits.
  logic [`SVOT_LINK_CNT_W-1:0] lk_cnt_r, lk_cnt_nxt;
  logic [3:0]                  lk_frm_r, lk_frm_nxt;
  logic                        tx_r, tx_nxt;
  logic [2:0]                  lk_idx;

  assign lk_idx = lk_cnt_r[`SVOT_LINK_CNT_W-1:2];

  always_comb begin
    lk_cnt_nxt = lk_cnt_r + 5'h01;
    lk_frm_nxt = lk_frm_r;
    if (lk_cnt_r == 5'h00) begin
      lk_frm_nxt = {~(rb_s[1] ^ rb_s[0] ^ 1'b1), rb_s[0], rb_s[1], 1'b1};
    end
    tx_nxt = (lk_idx < `SVOT_LINK_DATA) ? lk_frm_nxt[lk_idx[1:0]] : 1'b0;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_cnt_r <= 5'h00;
      lk_frm_r <= 4'h0;
      tx_r     <= 1'b0;
    end else if (clk_en) begin
      lk_cnt_r <= lk_cnt_nxt;
      lk_frm_r <= lk_frm_nxt;
      tx_r     <= tx_nxt;
    end
  end

  // Proportional position loop scaled by the natural frequency term.
  // Output register loads zero while the valve is off, so stored drive clears one cycle after the valve closes.
  logic [15:0]        gain;
  logic signed [16:0] err;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic [15:0]        ctl_r, ctl_nxt;

  svot_natfreq u_natfreq (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .clk_en         (clk_en),
    .params_load    (params_load),
    .axis_stiffness (axis_stiffness),
    .axis_mass      (axis_mass),
    .natfreq_busy   (natfreq_busy),
    .natfreq_sq     (natfreq_sq)
  );

  always_comb begin
    gain   = (natfreq_sq[31:16] != 16'h0000) ? 16'hFFFF : natfreq_sq[15:0];
    err    = $signed({pos_setpoint[15], pos_setpoint}) - $signed({pos_actual[15], pos_actual});
    prod   = err * $signed({1'b0, gain});
    scaled = prod >>> `SVOT_GAIN_SHIFT;
    if (!(hs_r && ls_r)) begin
      ctl_nxt = 16'h0000;
    end else if (scaled > 34'sh0000_7FFF) begin
      ctl_nxt = 16'h7FFF;
    end else if (scaled < -34'sh0000_8000) begin
      ctl_nxt = 16'h8000;
    end else begin
      ctl_nxt = scaled[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= 16'h0000;
    end else if (clk_en) begin
      ctl_r <= ctl_nxt;
    end
  end

  assign hs_switch_on    = hs_r;
  assign ls_switch_on    = ls_r;
  assign valve_energized = hs_r & ls_r;
  assign ch1_valve_fault = f1_r;
  assign ch2_valve_fault = f2_r;
  assign test_busy       = !stable && (st_r != SVOT_FAULT);
  assign link_tx         = tx_r;
  assign ctrl_out        = ctl_r;
endmodule : svot_top
`default_nettype wire

/* File: verification/svot_valve_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Valve and readback stage seen from the pins; the fault inputs let the bench break it on purpose.
module svot_valve_model (
  input  wire logic hs_switch_on,
  input  wire logic ls_switch_on,
  input  wire logic rb_stuck_lo,
  input  wire logic fb_bad,
  output logic      diag_hi_pin,
  output logic      diag_lo_pin,
  output logic      valve_fb_pin
);
  assign diag_hi_pin  = hs_switch_on;
  // The low-side node only carries voltage when the high side feeds it.
  assign diag_lo_pin  = hs_switch_on & ls_switch_on & ~rb_stuck_lo;
  assign valve_fb_pin = (hs_switch_on & ls_switch_on) ^ fb_bad;
endmodule : svot_valve_model
`default_nettype wire

/* File: verification/svot_checker_props.sv */
`timescale 1ns/10ps
`default_nettype none
module svot_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic safe_stop_request,
  input wire logic diag_lo_pin,
  input wire logic fault_clear,
  input wire logic hs_switch_on,
  input wire logic ls_switch_on,
  input wire logic valve_energized,
  input wire logic ch1_valve_fault,
  input wire logic ch2_valve_fault,
  input wire logic test_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_valve_series: assert property (valve_energized == (hs_switch_on && ls_switch_on))
    else $error("valve drive differs from switch pair");
  a_open_order: assert property ($rose(ls_switch_on) |-> $past(hs_switch_on, 50))
    else $error("low side closed before high side settled");
  a_close_order: assert property ($fell(hs_switch_on) && !ch1_valve_fault && !ch2_valve_fault
    |-> !$past(ls_switch_on, 50)) else $error("high side opened before low side settled");
  a_pass_start: assert property ($changed(safe_stop_request) && !test_busy
    && (valve_energized == safe_stop_request) && !ch1_valve_fault && !ch2_valve_fault
    |-> ##[2:4] test_busy) else $error("no test pass after stop change");
  a_stop_off: assert property ($rose(safe_stop_request) |-> ##[1:400] !valve_energized)
    else $error("valve still energized after stop");
  a_fault_off: assert property (ch1_valve_fault || ch2_valve_fault
    |-> !hs_switch_on && !ls_switch_on) else $error("switch closed during fault");
  a_fault_hold: assert property (ch1_valve_fault && !fault_clear |=> ch1_valve_fault)
    else $error("fault dropped without clear");
  a_rb_fault: assert property ((valve_energized && !test_busy && !diag_lo_pin)[*3]
    |-> ##[0:60] (ch1_valve_fault && ch2_valve_fault)) else $error("readback mismatch missed");
endmodule : svot_checker
bind svot_top svot_checker u_svot_checker (.sys_clk, .reset_n, .safe_stop_request,
  .diag_lo_pin, .fault_clear, .hs_switch_on, .ls_switch_on, .valve_energized,
  .ch1_valve_fault, .ch2_valve_fault, .test_busy);
`default_nettype wire

/* File: verification/shutoff_valve_output_test_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module shutoff_valve_output_test_bench;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        stop = 1'b0;
  logic        fault_clear = 1'b0;
  logic        params_load = 1'b0;
  logic        rb_stuck_lo = 1'b0;
  logic        fb_bad = 1'b0;
  int          seed = 32'hC4D3F6BB;
  logic [31:0] stiff = 32'h0;
  logic [15:0] mass = 16'h0;
  logic [15:0] pos_set = 16'h1234;
  logic [15:0] pos_act = 16'h0;
  logic        hs, ls, venrg, f1, f2, busy, link_tx, nf_busy, d_hi, d_lo, v_fb;
  logic [31:0] nf_sq;
  logic [15:0] ctrl_out;
  logic [3:0]  exp_q[$];
  logic [3:0]  prev = 4'h0;
  int          err_total = 0;
  int          num_checks = 0;
  longint      gain_x;
  longint      ctl_x;

  always #20 sys_clk = ~sys_clk;

  svot_top #(.FB_CYC(20)) u_svot_top (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .safe_stop_request(stop), .diag_hi_pin(d_hi), .diag_lo_pin(d_lo), .valve_fb_pin(v_fb),
    .fault_clear(fault_clear), .ch1_valve_config(1'b1), .ch2_valve_config(1'b1),
    .params_load(params_load), .axis_stiffness(stiff), .axis_mass(mass),
    .pos_setpoint(pos_set), .pos_actual(pos_act), .hs_switch_on(hs), .ls_switch_on(ls),
    .valve_energized(venrg), .ch1_valve_fault(f1), .ch2_valve_fault(f2), .test_busy(busy),
    .link_tx(link_tx), .natfreq_busy(nf_busy), .natfreq_sq(nf_sq), .ctrl_out(ctrl_out));

  svot_valve_model u_svot_valve_model (.hs_switch_on(hs), .ls_switch_on(ls),
    .rb_stuck_lo(rb_stuck_lo), .fb_bad(fb_bad), .diag_hi_pin(d_hi), .diag_lo_pin(d_lo),
    .valve_fb_pin(v_fb));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  task results;
    $display("Checks: %0d, errors: %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // A start bit is the first high after at least 16 low cycles, since the frame tail is zero.
  task link_chk(input logic [1:0] rb);
    int z;
    logic [7:0] f;
    z = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge sys_clk);
      if (link_tx === 1'b1 && z >= 16) break;
      z = (link_tx === 1'b1) ? 0 : z + 1;
    end
    for (int k = 0; k < 8; k++) begin
      f[k] = link_tx;
      repeat (4) @(negedge sys_clk);
    end
    check({24'h0, f}, {28'h0, ~^{rb, 1'b1}, rb[0], rb[1], 1'b1});
    step(1);
  endtask : link_chk

  task clear_fault;
    stop = 1'b1;
    rb_stuck_lo = 1'b0;
    fb_bad = 1'b0;
    step(3);
    fault_clear = 1'b1;
    exp_q = {exp_q, 4'h0};
    step(5);
    fault_clear = 1'b0;
  endtask : clear_fault

  always @(negedge sys_clk) begin
    if (reset_n && {hs, ls, f1, f2} !== prev) begin
      check({hs, ls, f1, f2}, (exp_q.size() > 0) ? exp_q.pop_front() : 4'hX);
      prev = {hs, ls, f1, f2};
    end
  end

  initial begin
    #(40 * 20000);
    err_total++;
    results();
  end

  initial begin
    step(5);
    reset_n = 1'b1;
    pos_act = $random(seed);
    exp_q = {exp_q, 4'h8, 4'hC};
    step(200);
    link_chk(2'h3);
    stop = 1'b1;
    exp_q = {exp_q, 4'h8, 4'h0};
    step(200);
    link_chk(2'h0);
    stop = 1'b0;
    exp_q = {exp_q, 4'h8, 4'hC, 4'h3};
    step(200);
    rb_stuck_lo = 1'b1;
    step(20);
    clear_fault();
    fb_bad = 1'b1;
    exp_q = {exp_q, 4'h3};
    step(60);
    clear_fault();
    // Reselect while the open pass sits in its second step.
    // The high-side step comes before the reselect, so both notes go in up front.
    exp_q = {exp_q, 4'h8, 4'h0};
    stop = 1'b0;
    step(70);
    stop = 1'b1;
    step(200);
    for (int i = 0; i < 2; i++) begin
      stiff = $random(seed);
      mass = (i == 0) ? 16'h0 : 16'($random(seed));
      params_load = 1'b1;
      step(1);
      params_load = 1'b0;
      for (int j = 0; j < 100 && (j < 2 || nf_busy !== 1'b0); j++) step(1);
      check({31'h0, nf_busy}, 32'h0);
      check(nf_sq, (mass == 16'h0) ? 32'hFFFFFFFF : stiff / mass);
      check({16'h0, ctrl_out}, 32'h0);
    end
    // Open again so the loop output is seen with the valve energized.
    stop = 1'b0;
    exp_q = {exp_q, 4'h8, 4'hC};
    step(5);
    check({31'h0, busy}, 32'h1);
    step(195);
    gain_x = (mass == 16'h0 || stiff / mass > 32'h0000FFFF) ? 64'hFFFF : stiff / mass;
    ctl_x = ($signed(pos_set) - $signed(pos_act)) * gain_x;
    ctl_x = ctl_x >>> 8;
    ctl_x = (ctl_x > 32767) ? 32767 : ((ctl_x < -32768) ? -32768 : ctl_x);
    check({16'h0, ctrl_out}, {16'h0, ctl_x[15:0]});
    check(exp_q.size(), 32'h0);
    results();
  end
endmodule : shutoff_valve_output_test_bench
`default_nettype wire
